// ---- prx_top.sv ----
`timescale 1ns/10ps
module prx_top #(
  parameter int DEPTH = 2
) (
  // Clocks and reset
  input wire logic clk,
  input wire logic link_clk,
  input wire logic rst_b,
  // Configuration straps
  input wire logic op_mode_strap_bit0,
  input wire logic op_mode_strap_bit1,
  input wire logic op_mode_strap_bit2,
  input wire logic reduced_interface_select_strap,
  input wire logic mgmt_addr_strap_bit0,
  input wire logic mgmt_addr_strap_bit1,
  input wire logic mgmt_addr_strap_bit2,
  // Captured configuration
  output logic [prx_pkg::MODE_W-1:0] op_mode,
  output logic reduced_if,
  output logic [prx_pkg::ADDR_W-1:0] mgmt_addr,
  output logic strap_valid,
  // Management port address check
  input wire logic [prx_pkg::ADDR_W-1:0] mgmt_req_addr,
  output logic mgmt_addr_hit,
  // Line status from the receive datapath
  input wire logic carrier_det,
  input wire logic collision_det,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic symbol_mode,
  // Decoded nibble stream
  input wire logic in_valid,
  output logic in_ready,
  input wire prx_pkg::prx_word_t in_word,
  // MAC-facing pins
  output logic rx_clk_out,
  output logic [prx_pkg::MII_W-1:0] rxd,
  output logic rx_dv,
  output logic rx_er_sym4,
  output logic crs,
  output logic col,
  output logic crs_dv
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // ---------------- Strap capture ----------------
  logic [6:0] strap_s1, strap_s2, strap_s3;
  logic [1:0] strap_cnt;
  logic strap_agree;

  assign strap_agree = (strap_s2 == strap_s3);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_s1 <= '0;
      strap_s2 <= '0;
      strap_s3 <= '0;
    end else begin
      strap_s1 <= {op_mode_strap_bit2, op_mode_strap_bit1,
                   op_mode_strap_bit0, reduced_interface_select_strap,
                   mgmt_addr_strap_bit2, mgmt_addr_strap_bit1,
                   mgmt_addr_strap_bit0};
      strap_s2 <= strap_s1;
      strap_s3 <= strap_s2;
    end
  end

  // Latched once the chain has filled after each reset release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_cnt <= 2'h0;
      strap_valid <= 1'b0;
      op_mode <= prx_pkg::MODE_RST;
      reduced_if <= 1'b0;
      mgmt_addr <= prx_pkg::ADDR_RST;
    end else if (!strap_valid) begin
      if (strap_cnt != prx_pkg::STRAP_SETTLE) begin
        strap_cnt <= strap_cnt + 2'h1;
      end else if (strap_agree) begin
        strap_valid <= 1'b1;
        op_mode <= strap_s3[6:4];
        reduced_if <= strap_s3[3];
        mgmt_addr <= strap_s3[2:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mgmt_addr_hit <= 1'b0;
    end else begin
      mgmt_addr_hit <= strap_valid && (mgmt_req_addr == mgmt_addr);
    end
  end

  // ---------------- Receive clock ----------------
  logic [prx_pkg::DIV_W-1:0] div_cnt, div_half;

  assign div_half = speed_100 ? prx_pkg::DIV_W'(prx_pkg::HALF_100)
                              : prx_pkg::DIV_W'(prx_pkg::HALF_10);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= '0;
      rx_clk_out <= 1'b0;
    end else if (reduced_if) begin
      div_cnt <= '0;
      rx_clk_out <= 1'b0;
    end else if (div_cnt >= div_half - prx_pkg::DIV_W'(1)) begin
      div_cnt <= '0;
      rx_clk_out <= !rx_clk_out;
    end else begin
      div_cnt <= div_cnt + prx_pkg::DIV_W'(1);
    end
  end

  // ---------------- Two-entry buffer ----------------
  prx_pkg::prx_word_t buf_mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr, rd_ptr;
  logic [PTR_W:0] buf_cnt, next_cnt;
  logic buf_full, buf_empty, push, store, pop, drop_echo;

  assign buf_full = (buf_cnt == (PTR_W+1)'(DEPTH));
  assign buf_empty = (buf_cnt == '0);
  // Ready is a flop, so it is judged on the count after this edge
  assign next_cnt = buf_cnt + (PTR_W+1)'(store) - (PTR_W+1)'(pop);
  assign push = in_valid && !buf_full;
  // Looped-back transmit words are dropped only in reduced mode at 10 Mb/s half duplex
  assign drop_echo = reduced_if && !speed_100 && !full_duplex;
  assign store = push && !(in_word.echo && drop_echo);

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction : ptr_inc

  always_ff @(posedge clk) begin
    if (store) begin
      buf_mem[wr_ptr] <= in_word;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      buf_cnt <= '0;
      in_ready <= 1'b1;
    end else begin
      if (store) begin
        wr_ptr <= ptr_inc(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= ptr_inc(rd_ptr);
      end
      buf_cnt <= next_cnt;
      in_ready <= (next_cnt != (PTR_W+1)'(DEPTH));
    end
  end

  // ---------------- Word handshake, core side ----------------
  prx_pkg::prx_word_t xfer_word;
  logic xfer_req, ack_s1, ack_s2, ack_s3, ack_seen, lk_ack;

  // Word register only changes while no request is outstanding
  assign pop = !buf_empty && (xfer_req == ack_seen);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      xfer_word <= '0;
      xfer_req <= 1'b0;
    end else if (pop) begin
      xfer_word <= buf_mem[rd_ptr];
      xfer_req <= !xfer_req;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_s3 <= 1'b0;
      ack_seen <= 1'b0;
    end else begin
      ack_s1 <= lk_ack;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
      if (ack_s2 == ack_s3) begin
        ack_seen <= ack_s3;
      end
    end
  end

  // ---------------- Level crossing ----------------
  prx_pkg::prx_lvl_t lvl_src, lvl_s1, lvl_s2, lvl_s3, lvl;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lvl_src <= '0;
    end else begin
      lvl_src <= '{carrier: carrier_det, collision: collision_det,
                   reduced: reduced_if, speed_100: speed_100,
                   symbol_mode: symbol_mode};
    end
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      lvl_s1 <= '0;
      lvl_s2 <= '0;
      lvl_s3 <= '0;
      lvl <= '0;
    end else begin
      lvl_s1 <= lvl_src;
      lvl_s2 <= lvl_s1;
      lvl_s3 <= lvl_s2;
      lvl <= (lvl_s2 & lvl_s3) | (lvl & (lvl_s2 | lvl_s3));
    end
  end

  // ---------------- Word handshake, link side ----------------
  logic req_s1, req_s2, req_s3, req_new;
  prx_pkg::prx_word_t hold;
  logic hold_v, consume;

  assign req_new = (req_s2 == req_s3) && (req_s3 != lk_ack);

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
    end else begin
      req_s1 <= xfer_req;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end
  end

  // Acknowledge only when the holding slot can take the word
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      lk_ack <= 1'b0;
      hold <= '0;
      hold_v <= 1'b0;
    end else if (req_new && (!hold_v || consume)) begin
      lk_ack <= req_s3;
      hold <= xfer_word;
      hold_v <= 1'b1;
    end else if (consume) begin
      hold_v <= 1'b0;
    end
  end

  // ---------------- Serialiser ----------------
  logic phase, in_frame, sfd_seen, step, slow;
  logic [prx_pkg::REP_W-1:0] rep;
  logic [7:0] sfd_sh;
  logic [1:0] dibit;
  logic [7:0] next_sh;

  assign slow = lvl.reduced && !lvl.speed_100;
  assign step = !slow || (rep == prx_pkg::REP_W'(prx_pkg::RMII_10M_REP - 1));
  assign dibit = phase ? hold.data[3:2] : hold.data[1:0];
  assign next_sh = {sfd_sh[5:0], dibit[0], dibit[1]};
  assign consume = hold_v && step && (!lvl.reduced || phase);

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      rep <= '0;
      phase <= 1'b0;
    end else if (!hold_v || step) begin
      rep <= '0;
      if (hold_v && lvl.reduced) begin
        phase <= !phase;
      end
    end else begin
      rep <= rep + prx_pkg::REP_W'(1);
    end
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      in_frame <= 1'b0;
    end else if (consume) begin
      in_frame <= !hold.last;
    end else if (!lvl.carrier && !hold_v) begin
      in_frame <= 1'b0;
    end
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      sfd_sh <= '0;
      sfd_seen <= 1'b0;
    end else if (!lvl.carrier || (consume && hold.last)) begin
      sfd_sh <= '0;
      sfd_seen <= 1'b0;
    end else if (hold_v && step && lvl.reduced) begin
      sfd_sh <= next_sh;
      if (next_sh == prx_pkg::SFD_PATTERN) begin
        sfd_seen <= 1'b1;
      end
    end
  end

  // ---------------- MAC-facing pins ----------------
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxd <= '0;
      rx_dv <= 1'b0;
      rx_er_sym4 <= 1'b0;
    end else if (lvl.reduced) begin
      rx_dv <= 1'b0;
      rxd[3:2] <= 2'h0;
      // Preamble shown as zeros at 10 Mb/s
      if (hold_v && (!slow || sfd_seen)) begin
        rxd[1:0] <= dibit;
      end else begin
        rxd[1:0] <= 2'h0;
      end
      rx_er_sym4 <= hold_v && hold.err;
    end else if (hold_v) begin
      rxd <= hold.data;
      rx_dv <= 1'b1;
      rx_er_sym4 <= lvl.symbol_mode ? hold.sym4 : hold.err;
    end else begin
      // Starved mid-frame: nibble missing, so flag the frame bad unless in symbol mode
      rxd <= '0;
      rx_dv <= 1'b0;
      rx_er_sym4 <= in_frame && !lvl.symbol_mode;
    end
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      crs <= 1'b0;
      col <= 1'b0;
      crs_dv <= 1'b0;
    end else begin
      crs <= !lvl.reduced && lvl.carrier;
      col <= !lvl.reduced && lvl.collision;
      crs_dv <= lvl.reduced && (lvl.carrier || hold_v);
    end
  end

endmodule : prx_top

// ---- prx_pkg.sv ----
package prx_pkg;

  // Core clock and the receive clock rates it is divided down to
  localparam int CLK_MHZ = 100;
  localparam int RXCLK_100_KHZ = 25000;
  localparam int RXCLK_10_KHZ = 2500;
  localparam int HALF_100 = CLK_MHZ * 1000 / RXCLK_100_KHZ / 2;
  localparam int HALF_10 = CLK_MHZ * 1000 / RXCLK_10_KHZ / 2;
  localparam int DIV_W = 6;

  // Interface widths
  localparam int MII_W = 4;
  localparam int RMII_W = 2;
  localparam int MODE_W = 3;
  localparam int ADDR_W = 3;

  // Reference clocks spent on each dibit at 10 Mb/s in reduced mode
  localparam int RMII_10M_REP = 10;
  localparam int REP_W = 4;

  // Start-of-frame delimiter, first bit on the wire leftmost
  localparam logic [7:0] SFD_PATTERN = 8'hab;

  // Reset values
  localparam logic [MODE_W-1:0] MODE_RST = 3'h7;
  localparam logic [ADDR_W-1:0] ADDR_RST = 3'h0;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // One decoded nibble from the receive datapath
  typedef struct packed {
    logic [MII_W-1:0] data;
    logic sym4;
    logic err;
    logic last;
    logic echo;
  } prx_word_t;

  // Levels handed to the link domain
  typedef struct packed {
    logic carrier;
    logic collision;
    logic reduced;
    logic speed_100;
    logic symbol_mode;
  } prx_lvl_t;

  localparam int LVL_W = $bits(prx_lvl_t);

endpackage : prx_pkg

// ---- prx_top_chk.sv ----
`timescale 1ns/10ps
module prx_top_chk #(
  parameter int DEPTH = 2
) (
  // Clocks and reset
  input wire logic clk,
  input wire logic link_clk,
  input wire logic rst_b,
  // Watched ports
  input wire logic [prx_pkg::MODE_W-1:0] op_mode,
  input wire logic reduced_if,
  input wire logic [prx_pkg::ADDR_W-1:0] mgmt_addr,
  input wire logic strap_valid,
  input wire logic [prx_pkg::ADDR_W-1:0] mgmt_req_addr,
  input wire logic mgmt_addr_hit,
  input wire logic speed_100,
  input wire logic rx_clk_out,
  input wire logic [prx_pkg::MII_W-1:0] rxd,
  input wire logic rx_dv,
  input wire logic crs,
  input wire logic col
);
  a_rmii_upper_zero: assert property (
    @(posedge link_clk) disable iff (!rst_b)
    reduced_if |-> rxd[3:2] == 2'h0)
    else $error("upper bits used");
  a_rmii_mii_quiet: assert property (
    @(posedge link_clk) disable iff (!rst_b)
    reduced_if |-> !(rx_dv || crs || col))
    else $error("mii pins active");
  a_addr_hit_set: assert property (
    @(posedge clk) disable iff (!rst_b)
    strap_valid && mgmt_req_addr == mgmt_addr |=> mgmt_addr_hit)
    else $error("address hit missed");
  a_addr_miss_clr: assert property (
    @(posedge clk) disable iff (!rst_b)
    mgmt_req_addr != mgmt_addr |=> !mgmt_addr_hit)
    else $error("false address hit");
  a_strap_valid_holds: assert property (
    @(posedge clk) disable iff (!rst_b)
    strap_valid |=> strap_valid)
    else $error("strap valid dropped");
  a_config_held: assert property (
    @(posedge clk) disable iff (!rst_b)
    strap_valid ##1 strap_valid |->
      $stable(op_mode) && $stable(mgmt_addr) && $stable(reduced_if))
    else $error("config changed");
  a_rxclk_rmii_low: assert property (
    @(posedge clk) disable iff (!rst_b)
    reduced_if [*3] |-> !rx_clk_out)
    else $error("rx clock runs in reduced mode");
  a_rxclk_fast_half: assert property (
    @(posedge clk) disable iff (!rst_b)
    ($rose(rx_clk_out) && $past(speed_100, 4)) ##0
      (speed_100 && !reduced_if) [*3] |-> $fell(rx_clk_out))
    else $error("fast rx clock half period");
endmodule : prx_top_chk

bind prx_top prx_top_chk #(.DEPTH(DEPTH)) u_chk (
  .clk, .link_clk, .rst_b, .op_mode, .reduced_if, .mgmt_addr,
  .strap_valid, .mgmt_req_addr, .mgmt_addr_hit, .speed_100,
  .rx_clk_out, .rxd, .rx_dv, .crs, .col
);

// ---- prx_mac_model.sv ----
`timescale 1ns/10ps
module prx_mac_model (
  // Link side
  input wire logic link_clk,
  input wire logic rst_b,
  input wire logic clr,
  input wire logic rmii,
  input wire logic [prx_pkg::MII_W-1:0] rxd,
  input wire logic rx_dv,
  input wire logic rx_er_sym4,
  input wire logic crs_dv,
  // Captured frame
  output logic [15:0] cap,
  output logic [7:0] er_cap,
  output logic [7:0] units,
  output logic hi_seen
);
  always_ff @(posedge link_clk) begin
    if (!rst_b || clr) begin
      cap <= '0;
      er_cap <= '0;
      units <= '0;
      hi_seen <= 1'b0;
    end else if (!rmii && rx_dv) begin
      cap <= {cap[11:0], rxd};
      er_cap <= {er_cap[6:0], rx_er_sym4};
      units <= units + 8'h1;
    end else if (rmii && crs_dv && rxd[1:0] != 2'h0) begin
      // Idle dibits are zero, so only live ones are kept
      cap <= {cap[13:0], rxd[1:0]};
      units <= units + 8'h1;
      hi_seen <= hi_seen | (rxd[1:0] == 2'h3);
    end
  end
endmodule : prx_mac_model

// ---- phy_mii_rmii_receive_side_bench.sv ----
`timescale 1ns/10ps
module phy_mii_rmii_receive_side_bench;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] ms = 3'h5;
  logic ss = 1'b0;
  logic [2:0] as = 3'h6;
  logic [2:0] req = 3'h0;
  logic car = 1'b0;
  logic cold = 1'b0;
  logic spd = 1'b1;
  logic fdx = 1'b1;
  logic sym = 1'b0;
  logic iv = 1'b0;
  logic clr = 1'b0;
  logic full = 1'b0;
  prx_pkg::prx_word_t iw = '0;
  logic [2:0] om, ma;
  logic [3:0] rxd;
  logic rif, sv, hit, ir, rck, dv, er, crs, col, cdv, hi;
  logic [15:0] cap;
  logic [7:0] erc, units;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  time t0;

  prx_top u_dut (
    .clk, .link_clk, .rst_b,
    .op_mode_strap_bit0(ms[0]), .op_mode_strap_bit1(ms[1]),
    .op_mode_strap_bit2(ms[2]), .reduced_interface_select_strap(ss),
    .mgmt_addr_strap_bit0(as[0]), .mgmt_addr_strap_bit1(as[1]),
    .mgmt_addr_strap_bit2(as[2]), .op_mode(om), .reduced_if(rif),
    .mgmt_addr(ma), .strap_valid(sv), .mgmt_req_addr(req),
    .mgmt_addr_hit(hit), .carrier_det(car), .collision_det(cold),
    .speed_100(spd), .full_duplex(fdx), .symbol_mode(sym),
    .in_valid(iv), .in_ready(ir), .in_word(iw), .rx_clk_out(rck),
    .rxd, .rx_dv(dv), .rx_er_sym4(er), .crs, .col, .crs_dv(cdv)
  );
  prx_mac_model u_mac (
    .link_clk, .rst_b, .clr, .rmii(ss), .rxd, .rx_dv(dv),
    .rx_er_sym4(er), .crs_dv(cdv), .cap, .er_cap(erc), .units,
    .hi_seen(hi)
  );

  initial forever #5 clk = ~clk;
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Config crosses in a few link edges
  task automatic lwait();
    repeat (10) @(posedge link_clk);
    @(negedge clk);
  endtask : lwait
  task automatic send(input logic [3:0] d, input logic [3:0] f);
    @(negedge clk);
    iv = 1'b1;
    iw = {d, f};
    while (!ir) begin
      full = 1'b1;
      @(negedge clk);
    end
  endtask : send
  // Drops valid after the last taken word, then waits for the MAC
  task automatic fin(input logic [7:0] n);
    @(negedge clk);
    iv = 1'b0;
    for (int k = 0; k < 3000 && units !== n; k++) @(negedge clk);
    lwait();
    car = 1'b0;
  endtask : fin
  task automatic start();
    clr = 1'b1;
    lwait();
    clr = 1'b0;
    full = 1'b0;
    car = 1'b1;
  endtask : start

  task automatic t_straps(input logic [2:0] m, input logic s,
                          input logic [2:0] a);
    @(negedge clk);
    ms = m;
    ss = s;
    as = a;
    rst_b = 1'b0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    repeat (10) @(negedge clk);
    chk(om, m);
    chk(rif, s);
    chk(ma, a);
    chk(sv, 1'b1);
    req = a;
    repeat (2) @(negedge clk);
    chk(hit, 1'b1);
    req = ~a;
    ms = ~m;
    ss = ~s;
    repeat (2) @(negedge clk);
    chk(hit, 1'b0);
    chk({om, rif}, {m, s});
    ms = m;
    ss = s;
  endtask : t_straps
  task automatic t_mii(input logic s);
    sym = s;
    start();
    send(4'h5, 4'h0);
    send(4'h3, 4'h0);
    send(4'ha, 4'h4);
    send(4'hc, 4'ha);
    fin(8'h4);
    chk(cap, 16'h53ac);
    chk(erc[2:0], s ? 3'h1 : 3'h2);
    chk(full, 1'b1);
  endtask : t_mii
  task automatic t_crs();
    car = 1'b1;
    lwait();
    chk({crs, col}, 2'h2);
    cold = 1'b1;
    lwait();
    chk(col, 1'b1);
    car = 1'b0;
    cold = 1'b0;
    lwait();
    chk({crs, col}, 2'h0);
  endtask : t_crs
  task automatic per(input int exp);
    repeat (2) @(posedge rck);
    t0 = $time;
    @(posedge rck);
    chk(16'(($time - t0) / 10), 16'(exp));
  endtask : per
  task automatic t_rmii(input logic fast);
    spd = fast;
    fdx = fast;
    start();
    lwait();
    chk(cdv, 1'b1);
    if (fast) begin
      send(4'h6, 4'h0);
      send(4'h9, 4'h2);
      fin(8'h4);
      chk(cap[7:0], 8'h96);
    end else begin
      // Preamble then delimiter, a looped word, one data word
      repeat (4) send(4'h5, 4'h0);
      send(4'hd, 4'h0);
      send(4'h3, 4'h1);
      send(4'h5, 4'h2);
      fin(8'(2 * prx_pkg::RMII_10M_REP));
      repeat (6) lwait();
      chk(units, 8'(2 * prx_pkg::RMII_10M_REP));
    end
    chk(hi, 1'b0);
    lwait();
    chk(cdv, 1'b0);
  endtask : t_rmii

  initial begin
    t_straps(3'h5, 1'b0, 3'h6);
    t_mii(1'b0);
    t_mii(1'b1);
    t_crs();
    per(2 * prx_pkg::HALF_100);
    @(negedge clk);
    spd = 1'b0;
    per(2 * prx_pkg::HALF_10);
    t_straps(3'h2, 1'b1, 3'h1);
    t_rmii(1'b1);
    t_rmii(1'b0);
    end_sim();
  end
endmodule : phy_mii_rmii_receive_side_bench
